// File: hdl/rsec_pkg.sv
// Package for the receive-signaling capture and error counter bank.
// Assumes one framer clock and one asynchronous reset domain.
package rsec_pkg;

	// Per-port register offsets (byte offsets inside a port window)
	localparam logic [7:0] RSEC_OFS_SIG_FIRST  = 8'h40;
	localparam logic [7:0] RSEC_OFS_SIG_LAST   = 8'h4f;
	localparam logic [7:0] RSEC_OFS_LCV_HIGH   = 8'h50;
	localparam logic [7:0] RSEC_OFS_LCV_LOW    = 8'h51;
	localparam logic [7:0] RSEC_OFS_PCV_HIGH   = 8'h52;
	localparam logic [7:0] RSEC_OFS_PCV_LOW    = 8'h53;
	localparam logic [7:0] RSEC_OFS_SLC_HIGH   = 8'h54;
	localparam logic [7:0] RSEC_OFS_SLC_LOW    = 8'h55;
	localparam logic [7:0] RSEC_OFS_IRQ_STATUS = 8'h70;
	localparam logic [7:0] RSEC_OFS_IRQ_MASK   = 8'h71;

	// Port window geometry
	localparam int         RSEC_PORT_STRIDE    = 32'h200;
	localparam int         RSEC_GROUP_STRIDE   = 32'h2000;
	localparam int         RSEC_PORTS_PER_GRP  = 8;

	// Interrupt status bit positions
	localparam int         RSEC_IRQ_SIG_CHG    = 0;
	localparam int         RSEC_IRQ_OOF_ENTRY  = 1;
	localparam int         RSEC_IRQ_CNT_WRAP   = 2;
	localparam int         RSEC_IRQ_BITS       = 3;

	// Reset values
	localparam logic [15:0] RSEC_CNT_RESET     = 16'h0000;
	localparam logic [7:0]  RSEC_BYTE_RESET    = 8'h00;

	// Signaling capture mode
	typedef enum logic [1:0] {
		RSEC_SIG_T1_ESF = 2'b00,
		RSEC_SIG_T1_D4  = 2'b01,
		RSEC_SIG_E1     = 2'b10
	} rsec_sig_mode_e;

endpackage : rsec_pkg

// File: hdl/rsec_counter.sv
// Saturation-free 16-bit event counter with a wrap pulse.
// Assumes the event input is a clean one-cycle pulse in the clk domain.
module rsec_counter
	import rsec_pkg::*;
#(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// Event and count
	input  wire logic             event_pulse,
	output logic      [WIDTH-1:0] count,
	output logic                  wrap
);

	logic [WIDTH-1:0] count_ff;
	logic             wrap_ff;
	wire  [WIDTH-1:0] nxt_count = count_ff + WIDTH'(1);
	wire              at_top    = &count_ff;

	// Rolls over rather than sticking; software sees the wrap as an event
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_ff <= WIDTH'(RSEC_CNT_RESET);
			wrap_ff  <= 1'b0;
		end else begin
			if (event_pulse) begin
				count_ff <= nxt_count;
			end
			wrap_ff <= event_pulse & at_top;
		end
	end

	assign count = count_ff;
	assign wrap  = wrap_ff;

endmodule : rsec_counter

// File: hdl/rsec_bank.sv
// Receive-signaling capture and error counter register bank, one port.
// Assumes a framer that delivers signaling updates per channel, error
// event pulses and an out-of-frame level, all in the clk domain.
//
// Notes on behaviour
// - T1: register k holds channel k ABCD high, channel k+12 low.
// - E1: first register upper nibble zero; others channel k-1, k+14.
// - ESF captures four bits A-D; D4 has only A and B.
// - In D4 the A and B values are copied into C and D.
// - Signaling capture freezes while out of frame.
// - Line violation count upper byte at offset 050h.
// - Line violation count lower byte at offset 051h.
// - Path violation count upper byte at offset 052h.
// - Path violation count lower byte readable in its own register.
// - Sync-loss count upper byte readable, bit 7 is count MSB.
// - Port window at 200h*(port-1) plus 2000h*floor((port-1)/8).
// - All count bytes read zero after reset.
// - Sixteen signaling bytes at offsets 040h through 04Fh.
// - Sync-loss count lower byte at offset 055h.
module rsec_bank
	import rsec_pkg::*;
#(
	parameter int          PORT_NUM  = 1,
	parameter int          ADDR_W    = 16,
	parameter logic [15:0] BASE_ADDR = 16'h0000
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// Framer side
	input  wire logic [1:0]        sig_mode,
	input  wire logic              out_of_frame,
	input  wire logic              sig_upd,
	input  wire logic [4:0]        sig_chan,
	input  wire logic [3:0]        sig_abcd,
	input  wire logic              line_violation,
	input  wire logic              path_violation,
	input  wire logic              sync_loss_event,
	// Interrupt
	output logic                   irq
);

	// Port window base address
	localparam int PORT_OFS = BASE_ADDR
		+ RSEC_PORT_STRIDE * (PORT_NUM - 1)
		+ RSEC_GROUP_STRIDE * ((PORT_NUM - 1) / RSEC_PORTS_PER_GRP);
	localparam logic [ADDR_W-1:0] PORT_BASE = ADDR_W'(PORT_OFS);

	// Signaling store: 32 channel nibbles, channel index 0 = first channel
	logic [3:0]  sig_ff [32];
	logic [7:0]  rdata_ff;
	logic        irq_ff;
	logic        oof_dly_ff;
	logic [RSEC_IRQ_BITS-1:0] status_ff;
	logic [RSEC_IRQ_BITS-1:0] mask_ff;

	logic [15:0] lcv_count;
	logic [15:0] pcv_count;
	logic [15:0] slc_count;
	logic        lcv_wrap;
	logic        pcv_wrap;
	logic        slc_wrap;

	// Address decode
	wire [ADDR_W-1:0] rel_addr  = reg_addr - PORT_BASE;
	wire              in_window = (reg_addr >= PORT_BASE)
		&& (rel_addr < ADDR_W'(RSEC_PORT_STRIDE));
	wire [7:0]        ofs       = rel_addr[7:0];
	wire              ofs_hi_ok = (rel_addr[ADDR_W-1:8] == '0);
	wire              hit       = in_window && ofs_hi_ok;
	wire              sig_hit   = hit && (ofs >= RSEC_OFS_SIG_FIRST)
		&& (ofs <= RSEC_OFS_SIG_LAST);
	wire [3:0]        sig_idx   = ofs[3:0];

	// Mode decode
	wire mode_d4 = (sig_mode == RSEC_SIG_T1_D4);
	wire mode_e1 = (sig_mode == RSEC_SIG_E1);

	// Only A and B exist in D4, so C and D take their values
	wire [3:0] cap_abcd = mode_d4 ? {sig_abcd[3:2], sig_abcd[3:2]}
		: sig_abcd;
	wire       cap_en   = sig_upd && !out_of_frame;

	// Channel nibble selection per register; T1 pairs k with k+12,
	// E1 pairs k-1 with k+14 and the first register has no high channel
	wire [4:0] t1_hi_ch = {1'b0, sig_idx};
	wire [4:0] t1_lo_ch = 5'({1'b0, sig_idx} + 5'h0c);
	wire [4:0] e1_hi_ch = 5'({1'b0, sig_idx} - 5'h01);
	wire [4:0] e1_lo_ch = 5'({1'b0, sig_idx} + 5'h0e);
	wire       e1_first = (sig_idx == 4'h0);
	wire       t1_gap   = (sig_idx > 4'hb);
	wire [3:0] hi_nib   = mode_e1
		? (e1_first ? 4'h0 : sig_ff[e1_hi_ch])
		: (t1_gap ? 4'h0 : sig_ff[t1_hi_ch]);
	wire [3:0] lo_nib   = mode_e1
		? (e1_first ? sig_ff[5'h0f] : sig_ff[e1_lo_ch])
		: (t1_gap ? 4'h0 : sig_ff[t1_lo_ch]);
	wire [7:0] sig_byte = {hi_nib, lo_nib};

	// Read mux
	wire [7:0] rd_mux =
		sig_hit                          ? sig_byte :
		!hit                             ? 8'h00 :
		(ofs == RSEC_OFS_LCV_HIGH)       ? lcv_count[15:8] :
		(ofs == RSEC_OFS_LCV_LOW)        ? lcv_count[7:0] :
		(ofs == RSEC_OFS_PCV_HIGH)       ? pcv_count[15:8] :
		(ofs == RSEC_OFS_PCV_LOW)        ? pcv_count[7:0] :
		(ofs == RSEC_OFS_SLC_HIGH)       ? slc_count[15:8] :
		(ofs == RSEC_OFS_SLC_LOW)        ? slc_count[7:0] :
		(ofs == RSEC_OFS_IRQ_STATUS)     ? 8'(status_ff) :
		(ofs == RSEC_OFS_IRQ_MASK)       ? 8'(mask_ff) :
		8'h00;

	// Only the interrupt registers accept writes
	wire wr_status = reg_wr && hit && (ofs == RSEC_OFS_IRQ_STATUS);
	wire wr_mask   = reg_wr && hit && (ofs == RSEC_OFS_IRQ_MASK);

	// Interrupt events
	wire sig_change = cap_en && (sig_ff[sig_chan] != cap_abcd);
	wire oof_entry  = out_of_frame && !oof_dly_ff;
	wire cnt_wrap   = lcv_wrap || pcv_wrap || slc_wrap;
	wire [RSEC_IRQ_BITS-1:0] irq_evt = {cnt_wrap, oof_entry, sig_change};
	wire [RSEC_IRQ_BITS-1:0] w1c     =
		wr_status ? reg_wdata[RSEC_IRQ_BITS-1:0] : '0;
	// Set wins over a simultaneous clear so no event is lost
	wire [RSEC_IRQ_BITS-1:0] nxt_status = (status_ff & ~w1c) | irq_evt;
	wire nxt_irq = |(nxt_status & mask_ff);

	// Signaling capture, one nibble per channel; host writes never land
	for (genvar ch = 0; ch < 32; ch++) begin : g_sig
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				sig_ff[ch] <= 4'h0;
			end else if (cap_en && (sig_chan == 5'(ch))) begin
				sig_ff[ch] <= cap_abcd;
			end
		end
	end

	// Read data, valid only the cycle after the strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_ff <= RSEC_BYTE_RESET;
		end else begin
			rdata_ff <= reg_rd ? rd_mux : RSEC_BYTE_RESET;
		end
	end

	// Interrupt status and mask
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			status_ff  <= '0;
			mask_ff    <= '0;
			irq_ff     <= 1'b0;
			oof_dly_ff <= 1'b0;
		end else begin
			status_ff  <= nxt_status;
			irq_ff     <= nxt_irq;
			oof_dly_ff <= out_of_frame;
			if (wr_mask) begin
				mask_ff <= reg_wdata[RSEC_IRQ_BITS-1:0];
			end
		end
	end

	// Error counters; the counting criteria live in the framer
	rsec_counter #(
		.WIDTH       (16)
	) u_lcv (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.event_pulse (line_violation),
		.count       (lcv_count),
		.wrap        (lcv_wrap)
	);

	rsec_counter #(
		.WIDTH       (16)
	) u_pcv (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.event_pulse (path_violation),
		.count       (pcv_count),
		.wrap        (pcv_wrap)
	);

	rsec_counter #(
		.WIDTH       (16)
	) u_slc (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.event_pulse (sync_loss_event),
		.count       (slc_count),
		.wrap        (slc_wrap)
	);

	assign reg_rdata = rdata_ff;
	assign irq       = irq_ff;

	// Checks
	sig_freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
		(out_of_frame && sig_upd) |=> (sig_ff[$past(sig_chan)]
			== $past(sig_ff[sig_chan])))
		else $error("signaling changed while out of frame");

	d4_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
		(cap_en && mode_d4) |=>
			(sig_ff[$past(sig_chan)][1:0] == sig_ff[$past(sig_chan)][3:2]))
		else $error("D4 capture did not copy A and B into C and D");

	esf_capture_a: assert property (@(posedge clk) disable iff (sys_rst)
		(cap_en && sig_mode == RSEC_SIG_T1_ESF) |=>
			(sig_ff[$past(sig_chan)] == $past(sig_abcd)))
		else $error("ESF capture lost a signaling bit");

	e1_first_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && sig_hit && mode_e1 && e1_first) |=>
			(reg_rdata[7:4] == 4'h0 && reg_rdata[3:0] == $past(sig_ff[15])))
		else $error("first E1 signaling byte wrong");

	t1_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && sig_hit && !mode_e1 && !t1_gap) |=>
			(reg_rdata == {$past(sig_ff[t1_hi_ch]), $past(sig_ff[t1_lo_ch])}))
		else $error("T1 signaling pairing wrong");

	lcv_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && hit && ofs == RSEC_OFS_LCV_HIGH) |=>
			(reg_rdata == $past(lcv_count[15:8])))
		else $error("line count high byte wrong");

	slc_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && hit && ofs == RSEC_OFS_SLC_LOW) |=>
			(reg_rdata == $past(slc_count[7:0])))
		else $error("sync loss count low byte wrong");

	write_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_wr && !line_violation) |=> $stable(lcv_count))
		else $error("host write changed a counter");

	count_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		(path_violation) |=> (pcv_count == 16'($past(pcv_count) + 16'h1)))
		else $error("path count did not advance by one");

	irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
		##1 (irq == |($past(nxt_status) & $past(mask_ff))))
		else $error("interrupt does not follow masked status");

	lcv_low_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && hit && ofs == RSEC_OFS_LCV_LOW) |=>
			(reg_rdata == $past(lcv_count[7:0])))
		else $error("line count low byte wrong");

	pcv_high_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && hit && ofs == RSEC_OFS_PCV_HIGH) |=>
			(reg_rdata == $past(pcv_count[15:8])))
		else $error("path count high byte wrong");

	pcv_low_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && hit && ofs == RSEC_OFS_PCV_LOW) |=>
			(reg_rdata == $past(pcv_count[7:0])))
		else $error("path count low byte wrong");

	slc_high_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && hit && ofs == RSEC_OFS_SLC_HIGH) |=>
			(reg_rdata == $past(slc_count[15:8])))
		else $error("sync loss count high byte wrong");

	t1_gap_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && sig_hit && !mode_e1 && t1_gap) |=>
			(reg_rdata == 8'h00))
		else $error("unused T1 signaling byte not zero");

	e1_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && sig_hit && mode_e1 && !e1_first) |=>
			(reg_rdata == {$past(sig_ff[e1_hi_ch]), $past(sig_ff[e1_lo_ch])}))
		else $error("E1 signaling pairing wrong");

	miss_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && !hit) |=> (reg_rdata == 8'h00))
		else $error("read outside the port window not zero");

	// Read data must not linger, or a stale byte looks like a fresh one
	rd_idle_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!reg_rd) |=> (reg_rdata == 8'h00))
		else $error("read data stands without a read strobe");

	sig_wr_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_wr && !sig_upd) |=>
			(sig_ff[$past(sig_chan)] == $past(sig_ff[sig_chan])))
		else $error("host write changed a signaling nibble");

	pcv_wr_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_wr && !path_violation) |=> $stable(pcv_count))
		else $error("host write changed the path count");

	slc_wr_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_wr && !sync_loss_event) |=> $stable(slc_count))
		else $error("host write changed the sync loss count");

	lcv_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		(line_violation) |=> (lcv_count == 16'($past(lcv_count) + 16'h1)))
		else $error("line count did not advance by one");

	slc_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		(sync_loss_event) |=> (slc_count == 16'($past(slc_count) + 16'h1)))
		else $error("sync loss count did not advance by one");

	pcv_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!path_violation) |=> $stable(pcv_count))
		else $error("path count moved without an event");

	irq_masked_a: assert property (@(posedge clk) disable iff (sys_rst)
		(mask_ff == '0) |=> !irq)
		else $error("interrupt raised with every source masked");

	sig_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		(sig_change) |=> status_ff[RSEC_IRQ_SIG_CHG])
		else $error("signaling change not flagged");

	oof_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		(oof_entry) |=> status_ff[RSEC_IRQ_OOF_ENTRY])
		else $error("out of frame entry not flagged");

endmodule : rsec_bank

// File: dv/rsec_framer_model.sv
// Framer-side model: signaling updates, out-of-frame level and error pulses.
// Assumes the bench calls its tasks; every change lands after a rising edge.
module rsec_framer_model
	import rsec_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Framer outputs
	output logic      [1:0] sig_mode,
	output logic            out_of_frame,
	output logic            sig_upd,
	output logic      [4:0] sig_chan,
	output logic      [3:0] sig_abcd,
	output logic            line_violation,
	output logic            path_violation,
	output logic            sync_loss_event
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sig_mode = 2'h0;
		out_of_frame = 1'b0;
		sig_upd = 1'b0;
		sig_chan = 5'h00;
		sig_abcd = 4'h0;
		line_violation = 1'b0;
		path_violation = 1'b0;
		sync_loss_event = 1'b0;
	end

	// Stale channel and data lines are inverted so a late capture shows up
	task automatic sig(input logic [4:0] ch, input logic [3:0] v);
		@(posedge clk);
		sig_upd <= 1'b1;
		sig_chan <= ch;
		sig_abcd <= v;
		@(posedge clk);
		sig_upd <= 1'b0;
		sig_chan <= ~ch;
		sig_abcd <= ~v;
	endtask

	task automatic ev(input int k);
		@(posedge clk);
		line_violation <= (k == 0);
		path_violation <= (k == 1);
		sync_loss_event <= (k == 2);
		@(posedge clk);
		line_violation <= 1'b0;
		path_violation <= 1'b0;
		sync_loss_event <= 1'b0;
	endtask

	task automatic set_mode(input logic [1:0] m);
		@(posedge clk);
		sig_mode <= m;
	endtask

	task automatic set_oof(input logic b);
		@(posedge clk);
		out_of_frame <= b;
	endtask
endmodule // rsec_framer_model

// File: dv/tb_rsec_bank.sv
// Testbench for the signaling capture and counter bank, one port.
// Assumes the framer model drives every framer-side input.
module tb_rsec_bank;
	import rsec_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// Port 10 lies in the second group, so both strides matter
	localparam logic [15:0] PB = 16'h3200;

	logic        clk, sys_rst, reg_wr, reg_rd;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata;
	// Driven by the instances, so these are nets and not bench variables
	wire  logic       irq;
	wire  logic [7:0] reg_rdata;
	wire  logic [1:0] sig_mode;
	wire  logic       out_of_frame, sig_upd, lv, pv, sl;
	wire  logic [4:0] sig_chan;
	wire  logic [3:0] sig_abcd;
	int          n_fail = 0;
	int          cmp_count = 0;

	rsec_bank #(.PORT_NUM(10), .ADDR_W(16), .BASE_ADDR(16'h0000))
	rsec_bank_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sig_mode(sig_mode),
		.out_of_frame(out_of_frame), .sig_upd(sig_upd),
		.sig_chan(sig_chan), .sig_abcd(sig_abcd), .line_violation(lv),
		.path_violation(pv), .sync_loss_event(sl), .irq(irq));

	rsec_framer_model fm (.clk(clk), .sig_mode(sig_mode),
		.out_of_frame(out_of_frame), .sig_upd(sig_upd),
		.sig_chan(sig_chan), .sig_abcd(sig_abcd), .line_violation(lv),
		.path_violation(pv), .sync_loss_event(sl));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe, so sample there
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	task automatic complete_run();
		$display("Compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#200us;
		n_fail++;
		complete_run();
	end

	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 6; i++)
			rd(PB + 16'h0050 + 16'(i), 8'h00);
		// Line count crosses a byte boundary to expose both halves
		repeat (259) fm.ev(0);
		repeat (2) fm.ev(1);
		fm.ev(2);
		rd(PB + 16'h0050, 8'h01);
		rd(PB + 16'h0051, 8'h03);
		rd(PB + 16'h0052, 8'h00);
		rd(PB + 16'h0053, 8'h02);
		rd(PB + 16'h0054, 8'h00);
		rd(PB + 16'h0055, 8'h01);
		rd(16'h0050, 8'h00);
		rd(PB + 16'h0060, 8'h00);
		wr(PB + 16'h0051, 8'hff);
		rd(PB + 16'h0051, 8'h03);
		// Host polls well inside the signaling refresh interval
		fm.sig(5'd0, 4'ha);
		fm.sig(5'd12, 4'h5);
		fm.sig(5'd11, 4'h3);
		fm.sig(5'd23, 4'hc);
		rd(PB + 16'h0040, 8'ha5);
		rd(PB + 16'h004b, 8'h3c);
		wr(PB + 16'h0040, 8'h00);
		rd(PB + 16'h0040, 8'ha5);
		fm.set_mode(2'h1);
		fm.sig(5'd1, 4'hb);
		rd(PB + 16'h0041, 8'ha0);
		fm.set_mode(2'h0);
		fm.set_oof(1'b1);
		fm.sig(5'd0, 4'h0);
		rd(PB + 16'h0040, 8'ha5);
		fm.set_oof(1'b0);
		fm.set_mode(2'h2);
		fm.sig(5'd15, 4'h6);
		fm.sig(5'd14, 4'h1);
		fm.sig(5'd29, 4'hf);
		rd(PB + 16'h0040, 8'h06);
		rd(PB + 16'h0041, 8'ha6);
		rd(PB + 16'h004f, 8'h1f);
		// Masked events must not reach the interrupt line
		rd(PB + 16'h0070, 8'h03);
		chk({7'h00, irq}, 8'h00);
		wr(PB + 16'h0071, 8'h07);
		rd(PB + 16'h0071, 8'h07);
		chk({7'h00, irq}, 8'h01);
		wr(PB + 16'h0070, 8'h03);
		rd(PB + 16'h0070, 8'h00);
		chk({7'h00, irq}, 8'h00);
		complete_run();
	end
endmodule // tb_rsec_bank
